// ===== ies_pkg.sv
// Shared constants, command codes and carrier types of the status core.
package ies_pkg;

	// Event status register and enable mask share this bit layout.
	localparam int ESR_PON = 7;
	localparam int ESR_CME = 5;
	localparam int ESR_EXE = 4;
	localparam int ESR_DDE = 3;
	localparam int ESR_QYE = 2;
	localparam int ESR_OPC = 0;

	// Status byte layout.
	localparam int STB_OPER = 7;
	localparam int STB_MSS  = 6;
	localparam int STB_ESB  = 5;
	localparam int STB_MAV  = 4;
	localparam int STB_QUES = 3;
	localparam int STB_ERRQ = 2;

	// Reset values, masks and the completion reply character.
	localparam logic [7:0] ESE_RESET     = 8'h00;
	localparam logic [7:0] ESR_RESET     = 8'h00;
	localparam logic [7:0] SRE_RESET     = 8'h00;
	localparam logic [7:0] STB_RESET     = 8'h00;
	localparam logic [7:0] ESR_USED_MASK = 8'hBD;
	localparam logic [7:0] SRE_WR_MASK   = 8'hBF;
	localparam logic [7:0] ALL_ONES      = 8'hFF;
	localparam logic [7:0] ASCII_ONE     = 8'h31;

	// Identification text; maker, model and serial values are arbitrary.
	localparam int DATE_MAX    = 10;
	localparam int ID_HEAD_LEN = 19;
	localparam int ID_TAIL_LEN = 13;
	localparam logic [8*ID_HEAD_LEN-1:0] ID_HEAD = "MAKER,PSU-0500-0.4 ";
	localparam logic [8*ID_TAIL_LEN-1:0] ID_TAIL = ",E000000,V1.0";

	typedef enum logic [3:0] {
		IES_CMD_CLS,
		IES_CMD_ESE,
		IES_CMD_ESE_Q,
		IES_CMD_ESR_Q,
		IES_CMD_IDN_Q,
		IES_CMD_OPC,
		IES_CMD_OPC_Q,
		IES_CMD_SRE,
		IES_CMD_SRE_Q,
		IES_CMD_STB_Q
	} ies_cmd_e;

	typedef struct packed {
		logic       valid;
		ies_cmd_e   code;
		logic [7:0] arg;
	} ies_cmd_t;

	typedef struct packed {
		logic cmdErr;
		logic exeErr;
		logic devErr;
		logic qryErr;
	} ies_evt_t;

	typedef struct packed {
		logic oper;
		logic ques;
		logic mav;
		logic errQue;
	} ies_sum_t;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} ies_resp_t;

endpackage

// ===== ies_status_core.sv
// Status reporting core: event status, enables, status byte, OPC and ID.
`timescale 1ns/1ns

module ies_status_core
	import ies_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire ies_cmd_t                cmdIn,
	input  wire ies_evt_t                evtIn,
	input  wire ies_sum_t                sumIn,
	input  wire logic                    opsPending,
	input  wire logic [8*DATE_MAX-1:0]   calDate,
	input  wire logic [3:0]              calDateLen,
	output logic                         cmdReady,
	output ies_resp_t                    respOut,
	output logic [7:0]                   statusByte,
	output logic                         clearPulse
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCQ_WAIT,
		ST_ID_HEAD,
		ST_ID_DATE,
		ST_ID_TAIL
	} ies_state_t;

	localparam logic [4:0] HEAD_LAST = 5'(ID_HEAD_LEN - 1);
	localparam logic [4:0] TAIL_LAST = 5'(ID_TAIL_LEN - 1);
	localparam logic [3:0] DATE_CAP  = 4'(DATE_MAX);

	ies_state_t state_reg;
	ies_resp_t  respOut_reg;
	logic [4:0] idx_reg;
	logic [7:0] esrReg;
	logic [7:0] esrNext;
	logic [7:0] eseReg;
	logic [7:0] sreReg;
	logic [7:0] statusByte_reg;
	logic [7:0] setBits;
	logic [7:0] clrBits;
	logic [7:0] esbTerm;
	logic [7:0] stbRaw;
	logic [3:0] dateLen;
	logic       cmdReady_reg;
	logic       clearPulse_reg;
	logic       ponPending_reg;
	logic       opcArmed_reg;
	logic       opcDone;
	logic       take;
	logic       isCls;

	assign cmdReady   = cmdReady_reg;
	assign respOut    = respOut_reg;
	assign statusByte = statusByte_reg;
	assign clearPulse = clearPulse_reg;

	// A command is taken only while the core says it is ready.
	assign take  = cmdIn.valid && cmdReady_reg;
	assign isCls = take && (cmdIn.code == IES_CMD_CLS);
	// Longer dates are cut so the field never exceeds its size.
	assign dateLen = (calDateLen > DATE_CAP) ? DATE_CAP : calDateLen;

	// Power-on is flagged once, in the first cycle after reset release.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			ponPending_reg <= 1'b1;
		else
			ponPending_reg <= 1'b0;
	end

	// Completion is watched in the background so the stream never stalls.
	assign opcDone = opcArmed_reg && !opsPending;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			opcArmed_reg <= 1'b0;
		else if (take && cmdIn.code == IES_CMD_OPC)
			opcArmed_reg <= 1'b1;
		else if (!opsPending)
			opcArmed_reg <= 1'b0;
	end

	// Event sets win over a read-clear or clear-status in the same cycle.
	always_comb
	begin
		setBits          = 8'h00;
		setBits[ESR_PON] = ponPending_reg;
		setBits[ESR_CME] = evtIn.cmdErr;
		setBits[ESR_EXE] = evtIn.exeErr;
		setBits[ESR_DDE] = evtIn.devErr;
		setBits[ESR_QYE] = evtIn.qryErr;
		setBits[ESR_OPC] = opcDone;
		clrBits = 8'h00;
		if (isCls || (take && cmdIn.code == IES_CMD_ESR_Q))
			clrBits = ALL_ONES;
		esrNext = ((esrReg & ~clrBits) | setBits) & ESR_USED_MASK;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			esrReg <= ESR_RESET;
		else
			esrReg <= esrNext;
	end

	// Enable masks change only on their own write commands.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			eseReg <= ESE_RESET;
			sreReg <= SRE_RESET;
		end
		else if (take && cmdIn.code == IES_CMD_ESE)
			eseReg <= cmdIn.arg;
		else if (take && cmdIn.code == IES_CMD_SRE)
			sreReg <= cmdIn.arg & SRE_WR_MASK;
	end

	// Summary terms, one per event bit.
	genvar gi;
	for (gi = 0; gi < 8; gi++)
	begin : g_esb
		assign esbTerm[gi] = esrReg[gi] & eseReg[gi];
	end

	always_comb
	begin
		stbRaw           = 8'h00;
		stbRaw[STB_OPER] = sumIn.oper;
		stbRaw[STB_ESB]  = |esbTerm;
		stbRaw[STB_MAV]  = sumIn.mav;
		stbRaw[STB_QUES] = sumIn.ques;
		stbRaw[STB_ERRQ] = sumIn.errQue;
		stbRaw[STB_MSS]  = |(stbRaw & sreReg);
	end

	// The byte is rebuilt every cycle, so it trails its sources by one.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			statusByte_reg <= STB_RESET;
		else if (isCls)
			statusByte_reg <= STB_RESET;
		else
			statusByte_reg <= stbRaw;
	end

	// One pulse empties the error queue and the other event registers.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			clearPulse_reg <= 1'b0;
		else
			clearPulse_reg <= isCls;
	end

	// Query answers and the identification stream.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg    <= ST_IDLE;
			respOut_reg  <= '0;
			idx_reg      <= 5'h00;
			cmdReady_reg <= 1'b1;
		end
		else
		begin
			respOut_reg.valid <= 1'b0;
			respOut_reg.last  <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					idx_reg <= 5'h00;
					if (take)
					begin
						case (cmdIn.code)
							IES_CMD_ESE_Q:
							begin
								respOut_reg <= {1'b1, 1'b1, eseReg};
							end
							IES_CMD_ESR_Q:
							begin
								respOut_reg <= {1'b1, 1'b1, esrReg};
							end
							IES_CMD_SRE_Q:
							begin
								respOut_reg <= {1'b1, 1'b1, sreReg};
							end
							IES_CMD_STB_Q:
							begin
								respOut_reg <= {1'b1, 1'b1, statusByte_reg};
							end
							IES_CMD_IDN_Q:
							begin
								state_reg    <= ST_ID_HEAD;
								cmdReady_reg <= 1'b0;
							end
							IES_CMD_OPC_Q:
							begin
								state_reg    <= ST_OPCQ_WAIT;
								cmdReady_reg <= 1'b0;
							end
							default:
							begin
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				ST_OPCQ_WAIT:
				begin
					// The link relies on the controller waiting for this byte.
					if (!opsPending)
					begin
						respOut_reg  <= {1'b1, 1'b1, ASCII_ONE};
						state_reg    <= ST_IDLE;
						cmdReady_reg <= 1'b1;
					end
				end
				ST_ID_HEAD:
				begin
					respOut_reg.valid <= 1'b1;
					respOut_reg.data  <= ID_HEAD[8*(HEAD_LAST-idx_reg) +: 8];
					idx_reg           <= idx_reg + 5'h01;
					if (idx_reg == HEAD_LAST)
					begin
						idx_reg   <= 5'h00;
						state_reg <= (dateLen == 4'h0) ? ST_ID_TAIL : ST_ID_DATE;
					end
				end
				ST_ID_DATE:
				begin
					respOut_reg.valid <= 1'b1;
					respOut_reg.data  <= calDate[8*idx_reg[3:0] +: 8];
					idx_reg           <= idx_reg + 5'h01;
					if (idx_reg[3:0] == dateLen - 4'h1)
					begin
						idx_reg   <= 5'h00;
						state_reg <= ST_ID_TAIL;
					end
				end
				ST_ID_TAIL:
				begin
					respOut_reg.valid <= 1'b1;
					respOut_reg.data  <= ID_TAIL[8*(TAIL_LAST-idx_reg) +: 8];
					idx_reg           <= idx_reg + 5'h01;
					if (idx_reg == TAIL_LAST)
					begin
						respOut_reg.last <= 1'b1;
						state_reg        <= ST_IDLE;
						cmdReady_reg     <= 1'b1;
					end
				end
				default:
				begin
					state_reg    <= ST_IDLE;
					cmdReady_reg <= 1'b1;
				end
			endcase
		end
	end

	// Checks on the status logic.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_cls_esr;
		isCls |=> (esrReg & ~$past(setBits)) == 8'h00;
	endproperty
	a_cls_esr: assert property (p_cls_esr)
		else $error("Clear-status left event bits set.");

	property p_cls_masks;
		isCls |=> eseReg == $past(eseReg) && sreReg == $past(sreReg);
	endproperty
	a_cls_masks: assert property (p_cls_masks)
		else $error("Clear-status altered an enable mask.");

	property p_cls_queue;
		isCls |=> clearPulse_reg && statusByte_reg == 8'h00;
	endproperty
	a_cls_queue: assert property (p_cls_queue)
		else $error("Clear-status did not clear queue and status byte.");

	property p_ese_write;
		take && cmdIn.code == IES_CMD_ESE |=> eseReg == $past(cmdIn.arg);
	endproperty
	a_ese_write: assert property (p_ese_write)
		else $error("Enable mask write not stored.");

	property p_esb;
		!isCls |=> statusByte_reg[STB_ESB] == $past(|(esrReg & eseReg));
	endproperty
	a_esb: assert property (p_esb)
		else $error("Event summary bit wrong.");

	property p_layout;
		esrReg[6] == 1'b0 && esrReg[1] == 1'b0;
	endproperty
	a_layout: assert property (p_layout)
		else $error("Unused event bit set.");

	property p_ese_query;
		take && cmdIn.code == IES_CMD_ESE_Q
			|=> respOut_reg.valid && respOut_reg.data == $past(eseReg);
	endproperty
	a_ese_query: assert property (p_ese_query)
		else $error("Enable mask query answer wrong.");

	property p_esr_read;
		take && cmdIn.code == IES_CMD_ESR_Q
			|=> respOut_reg.data == $past(esrReg)
			&& (esrReg & ~$past(setBits)) == 8'h00;
	endproperty
	a_esr_read: assert property (p_esr_read)
		else $error("Event register read did not return and clear.");

	property p_cmd_err;
		evtIn.cmdErr |=> esrReg[ESR_CME];
	endproperty
	a_cmd_err: assert property (p_cmd_err)
		else $error("Command error bit not set.");

	// A fresh completion command in the same cycle may keep the arm set.
	property p_opc_set;
		opcArmed_reg && !opsPending |=> esrReg[ESR_OPC]
			&& (!opcArmed_reg || $past(take && cmdIn.code == IES_CMD_OPC));
	endproperty
	a_opc_set: assert property (p_opc_set)
		else $error("Operation complete bit not set.");

	property p_opc_ready;
		take && cmdIn.code == IES_CMD_OPC |=> cmdReady_reg;
	endproperty
	a_opc_ready: assert property (p_opc_ready)
		else $error("Command stream stalled after OPC.");

	property p_opcq_one;
		state_reg == ST_OPCQ_WAIT && !opsPending
			|=> respOut_reg.valid && respOut_reg.data == ASCII_ONE
			&& cmdReady_reg;
	endproperty
	a_opcq_one: assert property (p_opcq_one)
		else $error("Completion byte not queued.");

	property p_opcq_hold;
		state_reg == ST_OPCQ_WAIT && opsPending |=> !cmdReady_reg;
	endproperty
	a_opcq_hold: assert property (p_opcq_hold)
		else $error("Command accepted while completion pending.");

	property p_mss;
		!isCls |=> statusByte_reg[STB_MSS] == $past(|(stbRaw & sreReg));
	endproperty
	a_mss: assert property (p_mss)
		else $error("Service summary bit wrong.");

	property p_stb_query;
		take && cmdIn.code == IES_CMD_STB_Q
			|=> respOut_reg.data == $past(statusByte_reg)
			&& eseReg == $past(eseReg);
	endproperty
	a_stb_query: assert property (p_stb_query)
		else $error("Status byte query answer wrong.");

	property p_date_len;
		state_reg == ST_ID_DATE |-> idx_reg < 5'(DATE_MAX);
	endproperty
	a_date_len: assert property (p_date_len)
		else $error("Date field longer than allowed.");

endmodule

// ===== ies_ctrl_model.sv
// Remote controller model: issues decoded commands and gathers replies.
`timescale 1ns/1ns

module ies_ctrl_model
	import ies_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      cmdReady,
	input  wire ies_resp_t respOut,
	output ies_cmd_t       cmdIn
);
	logic [7:0] rxQ[$];
	int         lastCnt = 0;

	// Start idle so no command is seen before reset ends.
	initial
	begin
		cmdIn = '0;
	end

	// Gather reply bytes mid-cycle, where each one stands settled.
	always @(negedge clock)
	begin
		if (respOut.valid === 1'b1)
		begin
			rxQ.push_back(respOut.data);
			if (respOut.last === 1'b1)
				lastCnt++;
		end
	end

	// Hold the command until a rising edge takes it, then drop it.
	// Ready is read at falling edges, where it cannot race its own update.
	task automatic send(input ies_cmd_e code, input logic [7:0] arg);
		logic seenReady;
		@(negedge clock);
		cmdIn = '{1'b1, code, arg};
		seenReady = cmdReady;
		while (seenReady !== 1'b1)
		begin
			@(negedge clock);
			seenReady = cmdReady;
		end
		@(posedge clock);
		@(negedge clock);
		cmdIn = '{1'b0, code, ~arg};
	endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the status reporting core.
`timescale 1ns/1ns

module tb_top
	import ies_pkg::*;
;
	logic                  clock;
	logic                  reset_n;
	ies_cmd_t              cmdIn;
	ies_evt_t              evtIn;
	ies_sum_t              sumIn;
	logic                  opsPending;
	logic [8*DATE_MAX-1:0] calDate;
	logic [3:0]            calDateLen;
	logic                  cmdReady;
	ies_resp_t             respOut;
	logic [7:0]            statusByte;
	logic                  clearPulse;
	int                    clearCnt = 0;
	logic [7:0]            got;
	int                    errorCnt;
	int                    checksDone;

	ies_status_core i_dut (
		.clock      (clock),
		.reset_n    (reset_n),
		.cmdIn      (cmdIn),
		.evtIn      (evtIn),
		.sumIn      (sumIn),
		.opsPending (opsPending),
		.calDate    (calDate),
		.calDateLen (calDateLen),
		.cmdReady   (cmdReady),
		.respOut    (respOut),
		.statusByte (statusByte),
		.clearPulse (clearPulse)
	);

	ies_ctrl_model i_ctrl (
		.clock    (clock),
		.cmdReady (cmdReady),
		.respOut  (respOut),
		.cmdIn    (cmdIn)
	);

	// Free-running clock, 10 ns period.
	always #5 clock = ~clock;

	// The clear pulse lasts one cycle, so each one is counted mid-cycle.
	always @(negedge clock)
	begin
		if (clearPulse === 1'b1)
			clearCnt <= clearCnt + 1;
	end

	task automatic chk8(input string what, input logic [7:0] exp,
		input logic [7:0] seen);
		checksDone++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Bounded wait for a final reply byte; a hang counts and ends the run.
	task automatic waitLast(input int lastBase);
		int n;
		n = 0;
		while (i_ctrl.lastCnt == lastBase && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		if (i_ctrl.lastCnt == lastBase)
		begin
			errorCnt++;
			reportAndStop();
		end
	endtask

	task automatic ask(input ies_cmd_e code, output logic [7:0] b);
		int qBase;
		int lBase;
		qBase = i_ctrl.rxQ.size();
		lBase = i_ctrl.lastCnt;
		i_ctrl.send(code, 8'h00);
		waitLast(lBase);
		b = i_ctrl.rxQ[qBase];
	endtask

	task automatic pulse(input ies_evt_t e);
		@(negedge clock);
		evtIn = e;
		@(negedge clock);
		evtIn = '0;
		repeat (2) @(negedge clock);
	endtask

	task automatic t_power();
		ask(IES_CMD_ESE_Q, got);
		chk8("mask at reset", 8'h00, got);
		ask(IES_CMD_ESR_Q, got);
		chk8("power on event", 8'h80, got);
		ask(IES_CMD_ESR_Q, got);
		chk8("event after read", 8'h00, got);
		$display("done t_power");
	endtask

	task automatic t_events();
		sumIn = '{1'b0, 1'b1, 1'b0, 1'b0};
		i_ctrl.send(IES_CMD_ESE, 8'h3C);
		ask(IES_CMD_ESE_Q, got);
		chk8("mask readback", 8'h3C, got);
		pulse('1);
		chk8("summary bit", 8'h28, statusByte);
		i_ctrl.send(IES_CMD_SRE, 8'h68);
		ask(IES_CMD_SRE_Q, got);
		chk8("service mask bit 6", 8'h28, got);
		ask(IES_CMD_STB_Q, got);
		chk8("status byte", 8'h68, got);
		ask(IES_CMD_STB_Q, got);
		chk8("status reread", 8'h68, got);
		ask(IES_CMD_ESR_Q, got);
		chk8("error events", 8'h3C, got);
		repeat (2) @(negedge clock);
		chk8("summary after read", 8'h48, statusByte);
		$display("done t_events");
	endtask

	// The byte is judged in the cycle right after the clear is taken.
	task automatic t_clear();
		int c0;
		pulse('{1'b0, 1'b1, 1'b0, 1'b0});
		i_ctrl.send(IES_CMD_ESE, 8'hFF);
		sumIn = '0;
		c0 = clearCnt;
		i_ctrl.send(IES_CMD_CLS, 8'h00);
		chk8("byte cleared", 8'h00, statusByte);
		repeat (2) @(negedge clock);
		chk8("queue clear", 8'h01, 8'(clearCnt - c0));
		ask(IES_CMD_ESR_Q, got);
		chk8("event cleared", 8'h00, got);
		ask(IES_CMD_ESE_Q, got);
		chk8("mask kept", 8'hFF, got);
		$display("done t_clear");
	endtask

	task automatic t_opc();
		opsPending = 1'b1;
		i_ctrl.send(IES_CMD_OPC, 8'h00);
		ask(IES_CMD_ESE_Q, got);
		chk8("served while pending", 8'hFF, got);
		ask(IES_CMD_ESR_Q, got);
		chk8("complete held", 8'h00, got);
		opsPending = 1'b0;
		repeat (3) @(negedge clock);
		ask(IES_CMD_ESR_Q, got);
		chk8("complete set", 8'h01, got);
		$display("done t_opc");
	endtask

	task automatic t_opcq();
		int qBase;
		int lBase;
		int early;
		opsPending = 1'b1;
		qBase = i_ctrl.rxQ.size();
		lBase = i_ctrl.lastCnt;
		i_ctrl.send(IES_CMD_OPC_Q, 8'h00);
		repeat (20) @(negedge clock);
		early = i_ctrl.rxQ.size() - qBase;
		chk8("held off", 8'h00, {7'h00, cmdReady});
		chk8("no early reply", 8'h00, 8'(early));
		opsPending = 1'b0;
		waitLast(lBase);
		chk8("complete reply", 8'h31, i_ctrl.rxQ[qBase]);
		$display("done t_opcq");
	endtask

	// A reset in mid-run must restore the mask default and flag power-on.
	task automatic t_reset();
		@(negedge clock);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		ask(IES_CMD_ESE_Q, got);
		chk8("mask after reset", 8'h00, got);
		ask(IES_CMD_ESR_Q, got);
		chk8("power on again", 8'h80, got);
		$display("done t_reset");
	endtask

	// A length above ten must clamp, so the date is sent with twelve.
	task automatic t_idn();
		string d;
		logic [7:0] e[$];
		int qBase;
		int idLen;
		d = "04-20-2004";
		for (int k = 0; k < 10; k++)
			calDate[8*k+:8] = d[k];
		calDateLen = 4'hC;
		for (int k = 0; k < ID_HEAD_LEN; k++)
			e.push_back(ID_HEAD[8*(ID_HEAD_LEN-1-k)+:8]);
		for (int k = 0; k < 10; k++)
			e.push_back(d[k]);
		for (int k = 0; k < ID_TAIL_LEN; k++)
			e.push_back(ID_TAIL[8*(ID_TAIL_LEN-1-k)+:8]);
		qBase = i_ctrl.rxQ.size();
		ask(IES_CMD_IDN_Q, got);
		idLen = i_ctrl.rxQ.size() - qBase;
		chk8("id length", 8'(e.size()), 8'(idLen));
		foreach (e[k])
			chk8("id byte", e[k], i_ctrl.rxQ[qBase + k]);
		$display("done t_idn");
	endtask

	// Cut a hang short well beyond the expected run length.
	initial
	begin
		#200000;
		errorCnt++;
		reportAndStop();
	end

	// Main sequence.
	initial
	begin
		clock = 1'b0;
		reset_n = 1'b0;
		evtIn = '0;
		sumIn = '0;
		opsPending = 1'b0;
		calDate = '0;
		calDateLen = 4'h0;
		errorCnt = 0;
		checksDone = 0;
		repeat (10) @(negedge clock);
		reset_n = 1'b1;
		t_power();
		t_events();
		t_clear();
		t_opc();
		t_opcq();
		t_reset();
		t_idn();
		reportAndStop();
	end
endmodule
